// ==== verilog/rsc_pkg.sv ====
// Constants and types for the reluctance sensor configuration block.
// Assumes a 10 MHz clock and a register port driven by the serial front end.
//
// Behaviour
// - Fault class reported at bits 14:13.
// - Bit 10 set clears fault flags after read.
// - Bit 9 forces minimum hysteresis in limited mode.
// - Bit 8 selects limited or fully adaptive.
// - Bits 7:6 enable auto filter and hysteresis.
// - Bits 5:3 pick hysteresis level or off.
// - Bit 1 picks filtered or direct feedback.
// - Bit 0 picks falling-edge mask or filter.
package rsc_pkg;
    // ==========================================================
    // Register address and field positions
    localparam logic [7:0] RSC_CTRL_ADDR = 8'h51;
    localparam int RSC_FAULT_HI = 14;
    localparam int RSC_FAULT_LO = 13;
    localparam int RSC_DOUBLE_EDGE = 11;
    localparam int RSC_FLAG_CLR = 10;
    localparam int RSC_HYST_FORCE = 9;
    localparam int RSC_ADAPT_SEL = 8;
    localparam int RSC_MODE_HI = 7;
    localparam int RSC_MODE_LO = 6;
    localparam int RSC_LEVEL_HI = 5;
    localparam int RSC_LEVEL_LO = 3;
    localparam int RSC_DIAG_EN = 2;
    localparam int RSC_FB_SRC = 1;
    localparam int RSC_FE_SEL = 0;
    // Writable bits 11:0 (bit 12 reserved, 14:13 read only)
    localparam logic [15:0] RSC_WR_MASK = 16'h0fff;
    localparam logic [15:0] RSC_RESET_VAL = 16'h0000;
    // ==========================================================
    // Fault codes
    localparam logic [1:0] RSC_FLT_NONE = 2'h0;
    localparam logic [1:0] RSC_FLT_GND = 2'h1;
    localparam logic [1:0] RSC_FLT_OPEN = 2'h2;
    localparam logic [1:0] RSC_FLT_BAT = 2'h3;
    // Hysteresis level codes
    localparam logic [2:0] RSC_LVL_OFF = 3'h7;
    localparam logic [2:0] RSC_LVL_ALT = 3'h6;
    localparam logic [2:0] RSC_LVL_DEF = 3'h0;
    localparam logic [2:0] RSC_LVL_THREE = 3'h3;
    localparam logic [2:0] RSC_LVL_ONE = 3'h1;
    // ==========================================================
    // Decoded analog-side controls
    typedef struct packed {
        logic hystOff;      // Hysteresis disabled
        logic [2:0] level;  // Level 1..5 (0 when off)
        logic autoFilter;
        logic autoHyst;
        logic fullyAdaptive;
        logic feedbackFiltered;
        logic fallingFilter;
        logic doubleEdge;
        logic diagEnable;
    } rsc_ctrl_t;
endpackage

// ==== verilog/rsc_level_decode.sv ====
// Hysteresis level decoder for the reluctance sensor config block.
// Pure logic; the variant strap arrives already synchronised.
`timescale 1ns/1ps
module rsc_level_decode import rsc_pkg::*; (
    // Inputs
    input wire logic [2:0] levelCode,
    input wire logic variantB,
    // Outputs
    output logic [2:0] level,
    output logic hystOff
);
    // ==========================================================
    // Map code to level; default codes depend on variant
    always_comb begin
        hystOff = 1'b0;
        level = levelCode;
        case (levelCode)
            RSC_LVL_OFF: begin
                hystOff = 1'b1;
                level = 3'h0;
            end
            RSC_LVL_DEF, RSC_LVL_ALT: begin
                level = variantB ? RSC_LVL_ONE : RSC_LVL_THREE;
            end
            default: begin
                level = levelCode;
            end
        endcase
    end
endmodule // rsc_level_decode

// ==== verilog/reluctance_sensor_config.sv ====
// Control/status register of the reluctance sensor input stage.
// Assumes the serial front end gives one-cycle read and write strobes
// with an 8-bit address on clk; fault detector inputs are asynchronous.
`timescale 1ns/1ps
module reluctance_sensor_config import rsc_pkg::*; (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic softResetReq,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Analog side
    input wire logic [1:0] faultDetect,
    input wire logic variantB,
    input wire logic hystBelowMin,
    output rsc_ctrl_t ctrlOut,
    output logic hystForcePulse
);
    // ==========================================================
    // Storage
    logic [11:0] cfg_reg;        // Writable bits 11:0
    logic [1:0] fault_reg;       // Sticky fault class
    logic [1:0] fltSync1_reg;    // Synchroniser stage one
    logic [1:0] fltSync2_reg;    // Synchroniser stage two
    logic variantSync1_reg;      // Strap stage one
    logic variantSync2_reg;      // Strap stage two
    logic [2:0] level;           // Decoded threshold level
    logic hystOff;               // Decoded hysteresis off
    logic hit;                   // Access targets this register
    logic [1:0] faultNow;        // Settled detector class

    // Address match shared by read, write and force paths
    assign hit = (regAddr == RSC_CTRL_ADDR);
    // Only stage two feeds logic; stage one may still be settling
    assign faultNow = fltSync2_reg;

    // ==========================================================
    // Synchronise the asynchronous detector and strap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fltSync1_reg <= 2'h0;
            fltSync2_reg <= 2'h0;
            variantSync1_reg <= 1'b0;
            variantSync2_reg <= 1'b0;
        end else begin
            fltSync1_reg <= faultDetect;
            fltSync2_reg <= fltSync1_reg;
            variantSync1_reg <= variantB;
            variantSync2_reg <= variantSync1_reg;
        end
    end

    // ==========================================================
    // Configuration bits; both resets clear them
    always_ff @(posedge clk) begin
        if (!rst_n || softResetReq) begin
            cfg_reg <= RSC_RESET_VAL[11:0];
        end else if (regWr && hit) begin
            // Reserved bit 12 and fault bits are not stored
            cfg_reg <= regWdata[11:0] & RSC_WR_MASK[11:0];
        end
    end

    // ==========================================================
    // Fault flag: set by detector while diagnostics on; a new fault
    // wins over clear-on-read in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n || softResetReq) begin
            fault_reg <= RSC_FLT_NONE;
        end else if (cfg_reg[RSC_DIAG_EN] && faultNow != RSC_FLT_NONE) begin
            fault_reg <= faultNow;
        end else if (regRd && hit && cfg_reg[RSC_FLAG_CLR]) begin
            fault_reg <= RSC_FLT_NONE;
        end
    end

    // ==========================================================
    // Read data; registered so the output is a flop
    // Other addresses read zero so a stale word never leaks out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd && hit) begin
            regRdata <= {1'b0, fault_reg, 1'b0, cfg_reg};
        end else if (regRd) begin
            regRdata <= 16'h0000; // Unmapped reads zero
        end
    end

    // ==========================================================
    // Level decode
    rsc_level_decode uDecode (
        .levelCode(cfg_reg[RSC_LEVEL_HI:RSC_LEVEL_LO]),
        .variantB(variantSync2_reg),
        .level(level),
        .hystOff(hystOff)
    );

    // ==========================================================
    // Registered analog controls
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlOut <= '0;
        end else begin
            ctrlOut.hystOff <= hystOff;
            ctrlOut.level <= level;
            ctrlOut.autoFilter <= cfg_reg[RSC_MODE_HI];
            ctrlOut.autoHyst <= cfg_reg[RSC_MODE_LO];
            ctrlOut.fullyAdaptive <= cfg_reg[RSC_ADAPT_SEL];
            ctrlOut.feedbackFiltered <= cfg_reg[RSC_FB_SRC];
            ctrlOut.fallingFilter <= cfg_reg[RSC_FE_SEL];
            ctrlOut.doubleEdge <= cfg_reg[RSC_DOUBLE_EDGE];
            ctrlOut.diagEnable <= cfg_reg[RSC_DIAG_EN];
        end
    end

    // ==========================================================
    // Force pulse: write of bit 9 in limited mode snaps threshold
    // to minimum; the write itself is the event, the stored bit 9 drives nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hystForcePulse <= 1'b0;
        end else begin
            hystForcePulse <= regWr && hit && regWdata[RSC_HYST_FORCE]
                && !regWdata[RSC_ADAPT_SEL];
        end
    end

    // ==========================================================
    // Checks: force pulse
    // Pulse follows the written data, not the stored bit 8
    chk_force_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (regWr && hit && regWdata[9] && !regWdata[8]) |=> hystForcePulse)
        else $error("force pulse missing");

    // Fully adaptive writes must never snap the threshold
    chk_force_full: assert property (@(posedge clk) disable iff (!rst_n)
        (regWr && hit && regWdata[8]) |=> !hystForcePulse)
        else $error("force in fully adaptive mode");

    // A pulse always has its own write one cycle before
    chk_force_cause: assert property (@(posedge clk) disable iff (!rst_n)
        hystForcePulse |-> $past(regWr && hit && regWdata[9] && !regWdata[8]))
        else $error("force pulse without write");

    // ==========================================================
    // Checks: fault flag
    // Clear-on-read empties the flag unless a new fault lands
    chk_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
        (regRd && hit && cfg_reg[10] && !(cfg_reg[2] && faultNow != 2'h0)
        && !softResetReq) |=> fault_reg == 2'h0)
        else $error("flag not cleared on read");

    // Without clear-on-read and no new fault the flag holds, reads too
    chk_keep_read: assert property (@(posedge clk) disable iff (!rst_n)
        (!cfg_reg[10] && !(cfg_reg[2] && faultNow != 2'h0) && !softResetReq
        && !$past(softResetReq)) |=> $stable(fault_reg))
        else $error("fault changed without cause");

    // Read word carries the flag as it stood at the read edge
    chk_read_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (regRd && hit) |=> regRdata[14:13] == $past(fault_reg))
        else $error("fault field wrong");

    // Detector class is latched while diagnostics run
    chk_diag_set: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_reg[2] && faultNow != 2'h0 && !softResetReq) |=> fault_reg == $past(faultNow))
        else $error("fault not captured");

    // Normal mode never picks up a detector class
    chk_diag_off: assert property (@(posedge clk) disable iff (!rst_n)
        (!cfg_reg[2] && !(regRd && hit && cfg_reg[10]) && !softResetReq)
        |=> $stable(fault_reg))
        else $error("fault latched in normal mode");

    // ==========================================================
    // Checks: configuration storage
    // Soft reset clears fields and flag in one edge
    chk_soft_clear: assert property (@(posedge clk) disable iff (!rst_n)
        softResetReq |=> (cfg_reg == 12'h000 && fault_reg == 2'h0))
        else $error("soft reset did not clear");

    // A write here stores its low twelve bits
    chk_write_store: assert property (@(posedge clk) disable iff (!rst_n)
        (regWr && hit && !softResetReq) |=> cfg_reg == $past(regWdata[11:0]))
        else $error("write not stored");

    // Anything but a write here or a reset leaves the fields alone
    chk_other_addr: assert property (@(posedge clk) disable iff (!rst_n)
        (!(regWr && hit) && !softResetReq) |=> $stable(cfg_reg))
        else $error("fields changed without write");

    // ==========================================================
    // Checks: analog controls
    // Mode bits reach the analog side one cycle after storage
    chk_mode_out: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 {ctrlOut.autoFilter, ctrlOut.autoHyst} == $past(cfg_reg[7:6]))
        else $error("mode bits not forwarded");

    // Code seven turns hysteresis off
    chk_off_code: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_reg[5:3] == 3'h7) |=> ctrlOut.hystOff)
        else $error("hysteresis not off");

    // Codes one to five give their own level
    chk_level_code: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_reg[5:3] != 3'h0 && cfg_reg[5:3] < 3'h6)
        |=> (ctrlOut.level == $past(cfg_reg[5:3]) && !ctrlOut.hystOff))
        else $error("level code not forwarded");

    // Default codes follow the variant strap
    chk_level_default: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_reg[5:3] == 3'h0 || cfg_reg[5:3] == 3'h6)
        |=> ctrlOut.level == ($past(variantSync2_reg) ? 3'h1 : 3'h3))
        else $error("default level wrong for variant");

    // Feedback source and falling-edge choice forwarded
    chk_fb_edge: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (ctrlOut.feedbackFiltered == $past(cfg_reg[1])
        && ctrlOut.fallingFilter == $past(cfg_reg[0])))
        else $error("feedback or edge bit wrong");

    // Main scenarios reached
    cov_write: cover property (@(posedge clk) regWr && hit);
    cov_fault: cover property (@(posedge clk) fault_reg == 2'h3);
    cov_clear: cover property (@(posedge clk) fault_reg != 2'h0 ##1 fault_reg == 2'h0);
    cov_force: cover property (@(posedge clk) hystForcePulse);
    cov_keep: cover property (@(posedge clk) fault_reg != 2'h0 && regRd && hit && !cfg_reg[10]);
endmodule // reluctance_sensor_config

// ==== tb/rsc_sensor_model.sv ====
// Sensor-side stand-in: fault detector class and variant strap.
// Assumes the bench commands the fault class; outputs move just after clk.
`timescale 1ns/1ps
module rsc_sensor_model (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic [1:0] faultCmd,
    input wire logic variantCmd,
    // Sensor-side outputs
    output logic [1:0] faultDetect,
    output logic variantB
);
    // ==========================================================
    // Detector lags its command by a cycle, like a slow comparator
    always_ff @(posedge clk) begin
        faultDetect <= faultCmd;
        variantB <= variantCmd;
    end
endmodule // rsc_sensor_model

// ==== tb/reluctance_sensor_config_test.sv ====
// Self-checking bench for the reluctance sensor control/status register.
// Assumes the design package, the design and the sensor model come first.
`timescale 1ns/1ps
module reluctance_sensor_config_test import rsc_pkg::*;;
    // ==========================================================
    // Stimulus, observed signals and scoreboard
    logic clk = 1'b0, rst_n = 1'b0, softResetReq = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000, regRdata, d, e;
    logic [15:0] expQ[$]; // Expected read data, oldest first
    logic [1:0] faultCmd = 2'h0, faultDetect;
    logic variantCmd = 1'b0, variantB, hystForcePulse, rdSeen = 1'b0;
    rsc_ctrl_t ctrlOut;
    int fails = 0, checked = 0, seed = 5586;
    always #50 clk = ~clk;
    rsc_sensor_model SENS (.clk(clk), .faultCmd(faultCmd), .variantCmd(variantCmd),
        .faultDetect(faultDetect), .variantB(variantB));
    // Analog status input is ignored by the design, so it is tied
    reluctance_sensor_config DUT (.clk(clk), .rst_n(rst_n), .softResetReq(softResetReq),
        .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata),
        .regRdata(regRdata), .faultDetect(faultDetect), .variantB(variantB),
        .hystBelowMin(1'b0), .ctrlOut(ctrlOut), .hystForcePulse(hystForcePulse));
    // ==========================================================
    // Shared tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    // Read strobe plus a note of what must come back
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(x);
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    // Decoded controls; default codes depend on the variant strap
    function automatic rsc_ctrl_t expCtrl(input logic [15:0] v, input logic vb);
        logic [2:0] c;
        logic [2:0] lvl;
        c = v[5:3];
        lvl = (c == 3'h7) ? 3'h0 : (c == 3'h0 || c == 3'h6) ? (vb ? 3'h1 : 3'h3) : c;
        return {c == 3'h7, lvl, v[7], v[6], v[8], v[1], v[0], v[11], v[2]};
    endfunction
    task automatic give_verdict;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // Monitor: read data lands one cycle after the read edge
    always @(posedge clk) rdSeen <= regRd;
    always @(negedge clk) begin
        if (rdSeen) begin
            e = expQ.pop_front();
            cmp(regRdata, e);
        end
    end
    // Watchdog; the whole sequence needs well under this
    initial begin
        idle(3000);
        fails++;
        give_verdict();
    end
    // ==========================================================
    // Main sequence
    initial begin
        idle(5);
        rst_n <= 1'b1;
        rd(8'h51, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            d = 16'($random(seed));
            d[5:3] = i[2:0];
            d[9] = 1'b0;
            variantCmd <= 1'($random(seed));
            idle(4);
            wr(8'h51, d);
            idle(1);
            #1 cmp({5'h00, ctrlOut}, {5'h00, expCtrl(d, variantB)});
            rd(8'h51, d & 16'h0fff);
        end
        rd(8'h22, 16'h0000); // Unmapped read zero after a nonzero read
        wr(8'h51, 16'h0200);
        #1 cmp({15'h0000, hystForcePulse}, 16'h0001);
        idle(1);
        #1 cmp({15'h0000, hystForcePulse}, 16'h0000);
        wr(8'h51, 16'h0300);
        #1 cmp({15'h0000, hystForcePulse}, 16'h0000);
        // Every fault class, cleared by its own read-out
        for (int f = 1; f < 4; f++) begin
            wr(8'h51, 16'h0404);
            faultCmd <= f[1:0];
            idle(5);
            faultCmd <= 2'h0;
            idle(5);
            rd(8'h51, {1'b0, f[1:0], 13'h0404});
            rd(8'h51, 16'h0404);
        end
        // Without clear-on-read the flags survive reading
        wr(8'h51, 16'h0004);
        faultCmd <= 2'h3;
        idle(5);
        faultCmd <= 2'h0;
        idle(5);
        rd(8'h51, 16'h6004);
        rd(8'h51, 16'h6004);
        softResetReq <= 1'b1;
        idle(1);
        softResetReq <= 1'b0;
        rd(8'h51, 16'h0000);
        // Write elsewhere must not turn diagnostics on
        wr(8'h50, 16'h0fff);
        faultCmd <= 2'h1;
        idle(6);
        rd(8'h51, 16'h0000);
        // Power-on reset in mid-run must clear written fields
        wr(8'h51, 16'h0fc7);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        rd(8'h51, 16'h0000);
        idle(3);
        give_verdict();
    end
endmodule // reluctance_sensor_config_test
